// [dcrb_pkg.sv]
// Package: offsets, field layouts and reset values of the configuration bank
package dcrb_pkg;
	localparam logic [31:0] ADDR_STRAP_A = 32'h4000_0000;
	localparam logic [31:0] ADDR_STRAP_B = 32'h4000_0004;
	localparam logic [31:0] ADDR_HOST_CFG = 32'h4000_0008;
	localparam logic [31:0] ADDR_HADDR_TOP = 32'h4000_000c;
	localparam logic [31:0] ADDR_HADDR_UMID = 32'h4000_0010;
	localparam logic [31:0] ADDR_CAPT_SRC = 32'h4000_0014;
	localparam logic [31:0] ADDR_MUTE0 = 32'h4000_0018;
	localparam logic [31:0] ADDR_MUTE1 = 32'h4000_001c;
	localparam logic [31:0] ADDR_MUTE2 = 32'h4000_0020;
	localparam logic [31:0] ADDR_BRIDGE = 32'h4000_0024;
	// Host port config fields
	localparam int HCFG_ENA_BIT = 0;
	localparam int HCFG_MUX_BIT = 1;
	localparam int HCFG_SEC_BIT = 2;
	localparam int HCFG_WIDTH = 3;
	// Byte-wide address registers
	localparam int BYTE_WIDTH = 8;
	// Capture source: two capture inputs, 3-bit event index each (0..5 valid)
	localparam int CAPT_SEL_WIDTH = 3;
	localparam int CAPT_WIDTH = 6;
	localparam int CAPT_SEL1_LSB = 4;
	localparam int CAPT_FIELD_GAP = 1;
	// Mute pin selection width
	localparam int MUTE_WIDTH = 4;
	localparam int BRIDGE_RST_BIT = 0;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	localparam logic [HCFG_WIDTH-1:0] HCFG_RESET = 3'h0;
	localparam logic [BYTE_WIDTH-1:0] BYTE_RESET = 8'h00;
	localparam logic [CAPT_WIDTH-1:0] CAPT_RESET = 6'h00;
	localparam logic [MUTE_WIDTH-1:0] MUTE_RESET = 4'h0;
	// Bridge held in reset after device reset until software releases it
	localparam logic BRIDGE_RST_RESET = 1'b1;
endpackage

// [dcrb_config_bank.sv]
// Device configuration register bank on a classic Wishbone slave
// Notes on behaviour
// - Two read-only registers hold eight strap pins each, caught at reset release.
// - Host port config register enables the host port and picks its addressing mode.
// - Top address byte register feeds host accesses when non-muxed or secured.
// - Upper middle address byte register applies under the same conditions.
// - Register picks which of six audio DMA events feed counter captures.
// - Three registers pick the pin feeding each audio port mute input.
// - Bridge control register asserts and releases internal bridge reset.
// - On the reduced variant the third mute-select register is reserved, no effect.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
module dcrb_config_bank #(
	parameter bit REDUCED_VARIANT = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] strapPinsA,
	input wire logic [7:0] strapPinsB,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic hostPortEnable,
	output logic hostPortNonMux,
	output logic hostAddrRegUse,
	output logic [7:0] hostAddrTopByte,
	output logic [7:0] hostAddrUpperMidByte,
	output logic [2:0] captureSel0,
	output logic [2:0] captureSel1,
	output logic [3:0] muteSelPort0,
	output logic [3:0] muteSelPort1,
	output logic [3:0] muteSelPort2,
	output logic bridgeReset
);
	logic [7:0] strapA_ff, nxt_strapA;
	logic [7:0] strapB_ff, nxt_strapB;
	logic inReset_ff, nxt_inReset;
	logic [dcrb_pkg::HCFG_WIDTH-1:0] hostCfg_ff, nxt_hostCfg;
	logic [7:0] haTop_ff, nxt_haTop;
	logic [7:0] haMid_ff, nxt_haMid;
	logic [dcrb_pkg::CAPT_WIDTH-1:0] capt_ff, nxt_capt;
	logic [3:0] mute0_ff, nxt_mute0;
	logic [3:0] mute1_ff, nxt_mute1;
	logic [3:0] mute2_ff, nxt_mute2;
	logic bridge_ff, nxt_bridge;
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic regUse_ff, nxt_regUse;
	logic wbReq;
	logic wrFire;

	// Only full-word writes land; partial lanes are ignored
	function automatic logic hit(input logic [31:0] adr, input logic [31:0] off);
		hit = (adr == off);
	endfunction

	assign wbReq = wb_cyc_i && wb_stb_i && !ack_ff;
	// Write lands on the edge where the master samples ack, not earlier
	assign wrFire = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && (wb_sel_i == 4'hf);

	// Strap capture: track reset, take pins on the first cycle after release
	always_comb
	begin
		nxt_inReset = 1'b0;
		nxt_strapA = strapA_ff;
		nxt_strapB = strapB_ff;
		if (inReset_ff)
		begin
			nxt_strapA = strapPinsA;
			nxt_strapB = strapPinsB;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			inReset_ff <= 1'b1;
			strapA_ff <= 8'h00;
			strapB_ff <= 8'h00;
		end
		else
		begin
			inReset_ff <= nxt_inReset;
			strapA_ff <= nxt_strapA;
			strapB_ff <= nxt_strapB;
		end
	end

	// Writable configuration
	always_comb
	begin
		nxt_hostCfg = hostCfg_ff;
		nxt_haTop = haTop_ff;
		nxt_haMid = haMid_ff;
		nxt_capt = capt_ff;
		nxt_mute0 = mute0_ff;
		nxt_mute1 = mute1_ff;
		nxt_mute2 = mute2_ff;
		nxt_bridge = bridge_ff;
		if (wrFire)
		begin
			if (hit(wb_adr_i, dcrb_pkg::ADDR_HOST_CFG))
				nxt_hostCfg = wb_dat_i[dcrb_pkg::HCFG_WIDTH-1:0];
			if (hit(wb_adr_i, dcrb_pkg::ADDR_HADDR_TOP))
				nxt_haTop = wb_dat_i[dcrb_pkg::BYTE_WIDTH-1:0];
			if (hit(wb_adr_i, dcrb_pkg::ADDR_HADDR_UMID))
				nxt_haMid = wb_dat_i[dcrb_pkg::BYTE_WIDTH-1:0];
			if (hit(wb_adr_i, dcrb_pkg::ADDR_CAPT_SRC))
			begin
				nxt_capt[2:0] = wb_dat_i[2:0];
				nxt_capt[5:3] = wb_dat_i[dcrb_pkg::CAPT_SEL1_LSB +: 3];
			end
			if (hit(wb_adr_i, dcrb_pkg::ADDR_MUTE0))
				nxt_mute0 = wb_dat_i[dcrb_pkg::MUTE_WIDTH-1:0];
			if (hit(wb_adr_i, dcrb_pkg::ADDR_MUTE1))
				nxt_mute1 = wb_dat_i[dcrb_pkg::MUTE_WIDTH-1:0];
			// Reserved slot on the reduced part: writes dropped
			if (hit(wb_adr_i, dcrb_pkg::ADDR_MUTE2) && !REDUCED_VARIANT)
				nxt_mute2 = wb_dat_i[dcrb_pkg::MUTE_WIDTH-1:0];
			if (hit(wb_adr_i, dcrb_pkg::ADDR_BRIDGE))
				nxt_bridge = wb_dat_i[dcrb_pkg::BRIDGE_RST_BIT];
		end
		// Registered so the output comes straight from a flop
		nxt_regUse = nxt_hostCfg[dcrb_pkg::HCFG_MUX_BIT] || nxt_hostCfg[dcrb_pkg::HCFG_SEC_BIT];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			hostCfg_ff <= dcrb_pkg::HCFG_RESET;
			haTop_ff <= dcrb_pkg::BYTE_RESET;
			haMid_ff <= dcrb_pkg::BYTE_RESET;
			capt_ff <= dcrb_pkg::CAPT_RESET;
			mute0_ff <= dcrb_pkg::MUTE_RESET;
			mute1_ff <= dcrb_pkg::MUTE_RESET;
			mute2_ff <= dcrb_pkg::MUTE_RESET;
			bridge_ff <= dcrb_pkg::BRIDGE_RST_RESET;
			regUse_ff <= 1'b0;
		end
		else
		begin
			hostCfg_ff <= nxt_hostCfg;
			haTop_ff <= nxt_haTop;
			haMid_ff <= nxt_haMid;
			capt_ff <= nxt_capt;
			mute0_ff <= nxt_mute0;
			mute1_ff <= nxt_mute1;
			mute2_ff <= nxt_mute2;
			bridge_ff <= nxt_bridge;
			regUse_ff <= nxt_regUse;
		end
	end

	// Bus answer: ack one cycle after request, dropped the following cycle
	always_comb
	begin
		nxt_ack = wbReq;
		nxt_rdat = dcrb_pkg::RD_UNMAPPED;
		if (wbReq && !wb_we_i)
		begin
			case (wb_adr_i)
				dcrb_pkg::ADDR_STRAP_A: nxt_rdat = {24'h0, strapA_ff};
				dcrb_pkg::ADDR_STRAP_B: nxt_rdat = {24'h0, strapB_ff};
				dcrb_pkg::ADDR_HOST_CFG: nxt_rdat = {29'h0, hostCfg_ff};
				dcrb_pkg::ADDR_HADDR_TOP: nxt_rdat = {24'h0, haTop_ff};
				dcrb_pkg::ADDR_HADDR_UMID: nxt_rdat = {24'h0, haMid_ff};
				dcrb_pkg::ADDR_CAPT_SRC: nxt_rdat = {25'h0, capt_ff[5:3], 1'b0, capt_ff[2:0]};
				dcrb_pkg::ADDR_MUTE0: nxt_rdat = {28'h0, mute0_ff};
				dcrb_pkg::ADDR_MUTE1: nxt_rdat = {28'h0, mute1_ff};
				dcrb_pkg::ADDR_MUTE2: nxt_rdat = {28'h0, mute2_ff};
				dcrb_pkg::ADDR_BRIDGE: nxt_rdat = {31'h0, bridge_ff};
				default: nxt_rdat = dcrb_pkg::RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= dcrb_pkg::RD_UNMAPPED;
		end
		else
		begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign hostPortEnable = hostCfg_ff[dcrb_pkg::HCFG_ENA_BIT];
	assign hostPortNonMux = hostCfg_ff[dcrb_pkg::HCFG_MUX_BIT];
	// Address registers steer accesses only when non-muxed or secured
	assign hostAddrRegUse = regUse_ff;
	assign hostAddrTopByte = haTop_ff;
	assign hostAddrUpperMidByte = haMid_ff;
	assign captureSel0 = capt_ff[2:0];
	assign captureSel1 = capt_ff[5:3];
	assign muteSelPort0 = mute0_ff;
	assign muteSelPort1 = mute1_ff;
	assign muteSelPort2 = mute2_ff;
	// Bridge reset sequencing after clock changes is software's job
	assign bridgeReset = bridge_ff;

	sequence s_req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	property p_ack_pulse;
		@(posedge core_clk) disable iff (rst)
		s_req_taken |=> s_ack_pulse;
	endproperty

	a_ack_one_cycle: assert property (p_ack_pulse)
		else $error("ack not a single cycle after request");

	property p_ack_needs_req;
		@(posedge core_clk) disable iff (rst)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty

	a_ack_needs_req: assert property (p_ack_needs_req)
		else $error("ack without a request");

	property p_rd_unmapped;
		@(posedge core_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > dcrb_pkg::ADDR_BRIDGE
		|=> wb_dat_o == dcrb_pkg::RD_UNMAPPED;
	endproperty

	a_rd_unmapped: assert property (p_rd_unmapped)
		else $error("unmapped read not zero");

	property p_rd_top;
		@(posedge core_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == dcrb_pkg::ADDR_HADDR_TOP
		|=> wb_dat_o == {24'h0, $past(haTop_ff)};
	endproperty

	a_rd_top_byte: assert property (p_rd_top)
		else $error("top byte read data wrong");

	property p_partial_ignored;
		@(posedge core_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i != 4'hf
		|=> $stable(hostPortEnable) && $stable(hostPortNonMux) && $stable(hostAddrRegUse);
	endproperty

	a_partial_ignored: assert property (p_partial_ignored)
		else $error("partial write changed host config");

	property p_strap_ro;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_STRAP_A |=> $stable(strapA_ff);
	endproperty

	a_strap_read_only: assert property (p_strap_ro)
		else $error("strap register written");

	property p_top_no_spurious;
		@(posedge core_clk) disable iff (rst)
		!(wrFire && wb_adr_i == dcrb_pkg::ADDR_HADDR_TOP) |=> $stable(hostAddrTopByte);
	endproperty

	a_top_no_spurious: assert property (p_top_no_spurious)
		else $error("top byte changed without write");

	property p_bridge_no_spurious;
		@(posedge core_clk) disable iff (rst)
		!(wrFire && wb_adr_i == dcrb_pkg::ADDR_BRIDGE) |=> $stable(bridgeReset);
	endproperty

	a_bridge_no_spurious: assert property (p_bridge_no_spurious)
		else $error("bridge reset changed without write");

	property p_host_mux_wr;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_HOST_CFG |=> hostPortNonMux == $past(wb_dat_i[1]);
	endproperty

	a_host_mux_wr: assert property (p_host_mux_wr)
		else $error("host mode not written");

	property p_reg_use_wr;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_HOST_CFG
		|=> hostAddrRegUse == ($past(wb_dat_i[1]) || $past(wb_dat_i[2]));
	endproperty

	a_reg_use_wr: assert property (p_reg_use_wr)
		else $error("address register use wrong");

	property p_capt0_wr;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_CAPT_SRC |=> captureSel0 == $past(wb_dat_i[2:0]);
	endproperty

	a_capt0_wr: assert property (p_capt0_wr)
		else $error("first capture select not written");

	property p_mute0_wr;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_MUTE0 |=> muteSelPort0 == $past(wb_dat_i[3:0]);
	endproperty

	a_mute0_wr: assert property (p_mute0_wr)
		else $error("port 0 mute select not written");

	property p_mute2_wr;
		@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_MUTE2 && !REDUCED_VARIANT
		|=> muteSelPort2 == $past(wb_dat_i[3:0]);
	endproperty

	a_mute2_wr: assert property (p_mute2_wr)
		else $error("port 2 mute select not written");

	a_strap_hold: assert property (@(posedge core_clk) disable iff (rst)
		!$past(inReset_ff) |-> $stable(strapA_ff) && $stable(strapB_ff))
		else $error("strap value changed after capture");
	a_host_cfg_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_HOST_CFG |=> hostPortEnable == $past(wb_dat_i[0]))
		else $error("host enable not written");
	a_addr_top_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_HADDR_TOP |=> hostAddrTopByte == $past(wb_dat_i[7:0]))
		else $error("top address byte not written");
	a_addr_mid_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_HADDR_UMID |=> hostAddrUpperMidByte == $past(wb_dat_i[7:0]))
		else $error("upper middle byte not written");
	a_capt_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_CAPT_SRC |=> captureSel1 == $past(wb_dat_i[6:4]))
		else $error("capture select not written");
	a_mute_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_MUTE1 |=> muteSelPort1 == $past(wb_dat_i[3:0]))
		else $error("mute select not written");
	a_mute2_reserved: assert property (@(posedge core_clk) disable iff (rst)
		REDUCED_VARIANT |-> muteSelPort2 == dcrb_pkg::MUTE_RESET)
		else $error("reserved mute select changed");
	a_bridge_wr: assert property (@(posedge core_clk) disable iff (rst)
		wrFire && wb_adr_i == dcrb_pkg::ADDR_BRIDGE |=> bridgeReset == $past(wb_dat_i[0]))
		else $error("bridge reset not written");
endmodule // dcrb_config_bank

// [dcrb_config_bank_tb_top.sv]
// Self-checking testbench for the device configuration register bank
`timescale 1ns/1ps
module dcrb_config_bank_tb_top;
	logic core_clk;
	logic rst;
	logic [7:0] strapA;
	logic [7:0] strapB;
	logic wbCyc;
	logic wbStb;
	logic wbWe;
	logic [31:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI;
	logic [31:0] wbDatO;
	logic wbAck;
	logic hpEna;
	logic hpNonMux;
	logic hpRegUse;
	logic [7:0] hpTop;
	logic [7:0] hpUmid;
	logic [2:0] cap0;
	logic [2:0] cap1;
	logic [3:0] mute0;
	logic [3:0] mute1;
	logic [3:0] mute2;
	logic brRst;
	logic [31:0] rdVal;
	logic [31:0] rdRed;
	logic [31:0] redDat;
	logic [3:0] redMute2;
	logic [3:0] muteOut [3];
	int fails = 0;
	int checked = 0;

	dcrb_config_bank uut (.core_clk(core_clk), .rst(rst), .strapPinsA(strapA),
		.strapPinsB(strapB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .hostPortEnable(hpEna), .hostPortNonMux(hpNonMux),
		.hostAddrRegUse(hpRegUse), .hostAddrTopByte(hpTop), .hostAddrUpperMidByte(hpUmid),
		.captureSel0(cap0), .captureSel1(cap1), .muteSelPort0(mute0),
		.muteSelPort1(mute1), .muteSelPort2(mute2), .bridgeReset(brRst));

	assign muteOut[0] = mute0;
	assign muteOut[1] = mute1;
	assign muteOut[2] = mute2;

	// Reduced variant shares the bus; only its reserved slot is watched
	dcrb_config_bank #(.REDUCED_VARIANT(1'b1)) uutReduced (.core_clk(core_clk), .rst(rst),
		.strapPinsA(strapA), .strapPinsB(strapB), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(redDat), .wb_ack_o(), .hostPortEnable(), .hostPortNonMux(),
		.hostAddrRegUse(), .hostAddrTopByte(), .hostAddrUpperMidByte(), .captureSel0(),
		.captureSel1(), .muteSelPort0(), .muteSelPort1(), .muteSelPort2(redMute2),
		.bridgeReset());

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Classic cycle: hold until ack, release, then one idle cycle
	task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
		input logic [3:0] sel);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatI <= dat;
		wbSel <= sel;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 50);
		rdVal = wbDatO;
		rdRed = redDat;
		if (n >= 50)
			chk("ack wait", 32'h1, 32'h0);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdChk(input string nm, input logic [31:0] adr, input logic [31:0] exp);
		xfer(1'b0, adr, 32'h0000_0000, 4'hf);
		chk(nm, exp, rdVal);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge core_clk);
		fails++;
		results();
	end

	initial
	begin
		rst = 1'b1;
		strapA = 8'ha5;
		strapB = 8'h3c;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 32'h0000_0000;
		wbSel = 4'h0;
		wbDatI = 32'h0000_0000;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		// Pins move after capture; registers must not follow
		strapA <= 8'h5a;
		strapB <= 8'hc3;
		rdChk("strap a", dcrb_pkg::ADDR_STRAP_A, 32'h0000_00a5);
		rdChk("strap b", dcrb_pkg::ADDR_STRAP_B, 32'h0000_003c);
		xfer(1'b1, dcrb_pkg::ADDR_STRAP_A, 32'h0000_00ff, 4'hf);
		rdChk("strap a ro", dcrb_pkg::ADDR_STRAP_A, 32'h0000_00a5);
		rdChk("host cfg rst", dcrb_pkg::ADDR_HOST_CFG, 32'h0000_0000);
		rdChk("capt rst", dcrb_pkg::ADDR_CAPT_SRC, 32'h0000_0000);
		rdChk("bridge rst", dcrb_pkg::ADDR_BRIDGE, 32'h0000_0001);
		chk("bridge out rst", 32'h1, {31'h0, brRst});
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, dcrb_pkg::ADDR_HOST_CFG, 32'(i), 4'hf);
			rdChk("host cfg", dcrb_pkg::ADDR_HOST_CFG, 32'(i));
			chk("host ena", 32'(i & 1), {31'h0, hpEna});
			chk("host nonmux", 32'((i >> 1) & 1), {31'h0, hpNonMux});
			chk("addr reg use", 32'((i >> 1) | (i >> 2)) & 32'h1, {31'h0, hpRegUse});
		end
		// Partial byte enables must leave the value untouched
		xfer(1'b1, dcrb_pkg::ADDR_HOST_CFG, 32'h0000_0000, 4'h1);
		chk("host sel", 32'h7, {29'h0, hpRegUse, hpNonMux, hpEna});
		xfer(1'b1, dcrb_pkg::ADDR_HADDR_TOP, 32'h0000_00a7, 4'hf);
		xfer(1'b1, dcrb_pkg::ADDR_HADDR_UMID, 32'h0000_005e, 4'hf);
		chk("top byte", 32'h0000_00a7, {24'h0, hpTop});
		chk("umid byte", 32'h0000_005e, {24'h0, hpUmid});
		rdChk("top rd", dcrb_pkg::ADDR_HADDR_TOP, 32'h0000_00a7);
		rdChk("umid rd", dcrb_pkg::ADDR_HADDR_UMID, 32'h0000_005e);
		xfer(1'b1, dcrb_pkg::ADDR_CAPT_SRC, 32'h0000_0053, 4'hf);
		chk("capture", 32'h0000_001d, {26'h0, cap0, cap1});
		rdChk("capt rd", dcrb_pkg::ADDR_CAPT_SRC, 32'h0000_0053);
		for (int p = 0; p < 3; p++)
		begin
			xfer(1'b1, dcrb_pkg::ADDR_MUTE0 + 32'(4 * p), 32'(9 + p), 4'hf);
			chk("mute out", 32'(9 + p), {28'h0, muteOut[p]});
			rdChk("mute rd", dcrb_pkg::ADDR_MUTE0 + 32'(4 * p), 32'(9 + p));
		end
		chk("reduced rd", 32'h0, rdRed);
		chk("reduced mute2", 32'h0, {28'h0, redMute2});
		xfer(1'b1, dcrb_pkg::ADDR_BRIDGE, 32'h0000_0000, 4'hf);
		chk("bridge release", 32'h0, {31'h0, brRst});
		// Clock change modelled: bridge put back in reset, then let go
		xfer(1'b1, dcrb_pkg::ADDR_BRIDGE, 32'h0000_0001, 4'hf);
		chk("bridge assert", 32'h1, {31'h0, brRst});
		xfer(1'b1, dcrb_pkg::ADDR_BRIDGE, 32'h0000_0000, 4'hf);
		chk("bridge rerelease", 32'h0, {31'h0, brRst});
		xfer(1'b1, 32'h4000_0028, 32'hffff_ffff, 4'hf);
		rdChk("unmapped", 32'h4000_0028, 32'h0000_0000);
		rdChk("capt kept", dcrb_pkg::ADDR_CAPT_SRC, 32'h0000_0053);
		results();
	end
endmodule // dcrb_config_bank_tb_top
